// ===== hdl/irq_ctl_pkg.sv
package irq_ctl_pkg;

   // Internal I/O addresses of the two I/O-mapped registers.
   localparam logic [7:0] VEC_LOW_ADDR = 8'h33;
   localparam logic [7:0] TRAP_CTL_ADDR = 8'h34;

   // Reset values.
   localparam logic [7:0] VEC_HIGH_RST = 8'h00;
   localparam logic [2:0] VEC_LOW_RST = 3'h0;
   localparam logic [2:0] EXT_EN_RST = 3'h1;

   // Field positions in the vector-low register.
   localparam int VEC_LOW_MSB = 7;
   localparam int VEC_LOW_LSB = 5;
   localparam int SRC_CODE_W = 5;

   // Field positions in the trap and interrupt control register.
   localparam int TRAP_FLAG_BIT = 7;
   localparam int FAULT_POS_BIT = 6;
   localparam int EXT_EN_MSB = 2;
   localparam int EXT_EN_LSB = 0;

   // Restart address of the trap.
   localparam logic [15:0] TRAP_RESTART = 16'h0000;

   // Wait states added to an external vector fetch.
   localparam int EXT_WAIT_STATES = 2;
   localparam logic [1:0] EXT_WAIT_LAST = 2'(EXT_WAIT_STATES - 1);

   // Timing figures; the clock runs at 10 MHz.
   localparam int CLK_PERIOD_NS = 100;

   // Register-port access from the instruction sequencer.
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } io_req_t;

   // One-cycle instruction and acceptance events from the sequencer.
   typedef struct packed {
      logic enable_irq_op;
      logic disable_irq_op;
      logic nonmaskable_return_op;
      logic irq_return_op;
      logic nmi_accept;
      logic irq_accept;
      logic ld_a_from_i;
      logic ld_a_from_r;
      logic ld_i_from_a;
   } core_ops_t;

   // Start of a vectored table fetch.
   typedef struct packed {
      logic start;
      logic external;
      logic [SRC_CODE_W-1:0] src_code;
   } vec_req_t;

   // Report of an undefined opcode fetch.
   typedef struct packed {
      logic fetch;
      logic third_byte;
      logic [15:0] pc;
   } undef_t;

   typedef enum logic [2:0] {
      VEC_IDLE,
      VEC_EXT_WAIT,
      VEC_RD_LOW,
      VEC_RD_HIGH
   } vec_state_t;

   typedef enum logic [1:0] {
      TRAP_IDLE,
      TRAP_INSERT,
      TRAP_AFTER
   } trap_state_t;

endpackage

// ===== hdl/vector_addr_gen.sv
`timescale 1ns/1ps
module vector_addr_gen (
   input wire logic [7:0] i_vec_high,
   input wire logic [7:0] i_vec_low,
   input wire logic i_second,
   output logic [15:0] o_addr
);
   import irq_ctl_pkg::*;

   logic [15:0] base;

   // The base's high byte always comes from the vector-high register, so tables sit on 256-byte pages.
   assign base = {i_vec_high, i_vec_low};

   // Entries are low byte first; the second read is one byte on.
   assign o_addr = i_second ? 16'(base + 16'h0001) : base;

endmodule

// ===== hdl/vectored_irq_and_trap_control.sv
`timescale 1ns/1ps
// Contract
// - Table address upper byte is the vector-high register, any 256-byte page.
// - Read restart address from the table, then resume there.
// - Vector-high clears on reset; accessed only by register-transfer ops.
// - Low table byte is vector-low bits 7-5 plus fixed five-bit code.
// - Vector-low relocates the table in 32-byte steps; clears on reset.
// - Vector-low at I/O 33H, page-zero output writes, input reads.
// - Bit 7 of 34H set on undefined opcode; write 0 clears, 1 ignored.
// - Read-only bit 6 tells whether the second or third byte trapped.
// - Control bits 2-0 enable external inputs 2, 1, 0; zero masks.
// - Global enable zero refuses all maskable requests; disable clears, enable sets.
// - Nonmaskable entry copies global to saved enable, then clears global.
// - Nonmaskable return copies saved to global; saved unchanged.
// - Reset and disable clear both flags; enable sets both.
// - Maskable acceptance clears both flags; normal return and trap leave them.
// - Loading accumulator from I or R copies global enable to parity flag.
// - Undefined opcode traps regardless of global enable, also in mode-0 acknowledge.
// - Trap sets the flag, pushes faulting counter, restarts at zero.
// - No bus-release, refresh, DMA or wait right after trap state.
// - External input 0 masked if global enable or its bit is zero.
// - Table entries are two-byte addresses, low byte first, up to 128.
// - External vector fetch gets two automatic wait states.
module vectored_irq_and_trap_control #(
   parameter int NUM_INT_SRC = 8
) (
   input wire logic i_core_clk,
   input wire logic i_rst,
   input irq_ctl_pkg::io_req_t i_io,
   input irq_ctl_pkg::core_ops_t i_ops,
   input wire logic [7:0] i_acc,
   input wire logic [2:0] i_ext_irq,
   input wire logic [NUM_INT_SRC-1:0] i_int_irq,
   input irq_ctl_pkg::vec_req_t i_vec,
   input wire logic [7:0] i_ext_vector,
   input wire logic i_mem_ack,
   input wire logic [7:0] i_mem_rdata,
   input irq_ctl_pkg::undef_t i_undef,
   output logic [7:0] o_io_rdata,
   output logic o_io_hit,
   output logic [7:0] o_vector_high,
   output logic o_pv_flag,
   output logic o_pv_valid,
   output logic o_global_irq_enable,
   output logic o_saved_irq_enable,
   output logic [2:0] o_ext_irq_req,
   output logic o_int_irq_req,
   output logic o_ext_vec_wait,
   output logic o_mem_rd,
   output logic [15:0] o_mem_addr,
   output logic o_restart_valid,
   output logic [15:0] o_restart_addr,
   output logic o_trap_state,
   output logic o_no_insert,
   output logic o_trap_push,
   output logic [15:0] o_trap_pc
);
   import irq_ctl_pkg::*;

   // Only a handful of internal sources exist; wider vectors have no fixed codes.
   if (NUM_INT_SRC < 1 || NUM_INT_SRC > 8) begin : g_bad_src
      $error("NUM_INT_SRC must lie between 1 and 8");
   end

   logic [7:0] vector_high;
   logic [2:0] vector_low_reg;
   logic trap_flag;
   logic fault_byte_position;
   logic [2:0] ext_en;
   logic global_irq_enable;
   logic saved_irq_enable;
   logic [7:0] next_vector_high;
   logic [2:0] next_vector_low_reg;
   logic next_trap_flag;
   logic next_fault_byte_position;
   logic [2:0] next_ext_en;
   logic next_global_irq_enable;
   logic next_saved_irq_enable;
   logic [7:0] trap_irq_control;
   logic vec_low_sel;
   logic trap_ctl_sel;

   // Decode of the two internal I/O addresses.
   // page-zero I/O decode
   assign vec_low_sel = (i_io.addr == VEC_LOW_ADDR);
   assign trap_ctl_sel = (i_io.addr == TRAP_CTL_ADDR);

   // Readback image of the control register.
   // unused bits zero
   always_comb begin
      trap_irq_control = 8'h00;
      trap_irq_control[TRAP_FLAG_BIT] = trap_flag;
      trap_irq_control[FAULT_POS_BIT] = fault_byte_position;
      trap_irq_control[EXT_EN_MSB:EXT_EN_LSB] = ext_en;
   end

   // Next values of the programmable registers and the two enable flags.
   always_comb begin
      next_vector_high = vector_high;
      next_vector_low_reg = vector_low_reg;
      next_trap_flag = trap_flag;
      next_fault_byte_position = fault_byte_position;
      next_ext_en = ext_en;
      next_global_irq_enable = global_irq_enable;
      next_saved_irq_enable = saved_irq_enable;
      if (i_ops.ld_i_from_a) begin
         next_vector_high = i_acc;
      end
      if (i_io.wr && vec_low_sel) begin
         next_vector_low_reg = i_io.wdata[VEC_LOW_MSB:VEC_LOW_LSB];
      end
      if (i_io.wr && trap_ctl_sel) begin
         next_ext_en = i_io.wdata[EXT_EN_MSB:EXT_EN_LSB];
         if (!i_io.wdata[TRAP_FLAG_BIT]) begin
            next_trap_flag = 1'b0;
         end
      end
      // The hardware set is applied last so an undefined fetch beats a clearing write.
      // hardware sets flag
      if (i_undef.fetch) begin
         next_trap_flag = 1'b1;
         next_fault_byte_position = i_undef.third_byte;
      end
      // Only one instruction or acceptance is expected at once; the order resolves accidents.
      // nonmaskable entry
      if (i_ops.nmi_accept) begin
         next_saved_irq_enable = global_irq_enable;
         next_global_irq_enable = 1'b0;
      end else if (i_ops.irq_accept) begin
         next_global_irq_enable = 1'b0;
         next_saved_irq_enable = 1'b0;
      end else if (i_ops.disable_irq_op) begin
         next_global_irq_enable = 1'b0;
         next_saved_irq_enable = 1'b0;
      end else if (i_ops.enable_irq_op) begin
         next_global_irq_enable = 1'b1;
         next_saved_irq_enable = 1'b1;
      end else if (i_ops.nonmaskable_return_op) begin
         next_global_irq_enable = saved_irq_enable;
      end
   end

   // Register state; reset values are constants only.
   // vector-high reset
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         vector_high <= VEC_HIGH_RST;
         vector_low_reg <= VEC_LOW_RST;
         trap_flag <= 1'b0;
         fault_byte_position <= 1'b0;
         ext_en <= EXT_EN_RST;
         global_irq_enable <= 1'b0;
         saved_irq_enable <= 1'b0;
      end else begin
         vector_high <= next_vector_high;
         vector_low_reg <= next_vector_low_reg;
         trap_flag <= next_trap_flag;
         fault_byte_position <= next_fault_byte_position;
         ext_en <= next_ext_en;
         global_irq_enable <= next_global_irq_enable;
         saved_irq_enable <= next_saved_irq_enable;
      end
   end

   logic [7:0] next_io_rdata;
   logic next_io_hit;
   logic next_pv_flag;
   logic next_pv_valid;
   logic [2:0] next_ext_irq_req;
   logic next_int_irq_req;

   // Read port, parity copy and masked request lines.
   always_comb begin
      next_io_rdata = 8'h00;
      next_io_hit = 1'b0;
      if (i_io.rd && vec_low_sel) begin
         next_io_rdata = {vector_low_reg, 5'h00};
         next_io_hit = 1'b1;
      end else if (i_io.rd && trap_ctl_sel) begin
         next_io_rdata = trap_irq_control;
         next_io_hit = 1'b1;
      end
      next_pv_valid = i_ops.ld_a_from_i | i_ops.ld_a_from_r;
      next_pv_flag = next_pv_valid ? global_irq_enable : o_pv_flag;
      // The request lines mirror the core flags one cycle late, which the sequencer tolerates.
      // global gate
      next_ext_irq_req = global_irq_enable ? (i_ext_irq & ext_en) : 3'h0;
      next_int_irq_req = global_irq_enable & (|i_int_irq);
   end

   // Registered report outputs.
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         o_io_rdata <= 8'h00;
         o_io_hit <= 1'b0;
         o_pv_flag <= 1'b0;
         o_pv_valid <= 1'b0;
         o_ext_irq_req <= 3'h0;
         o_int_irq_req <= 1'b0;
         o_vector_high <= VEC_HIGH_RST;
         o_global_irq_enable <= 1'b0;
         o_saved_irq_enable <= 1'b0;
      end else begin
         o_io_rdata <= next_io_rdata;
         o_io_hit <= next_io_hit;
         o_pv_flag <= next_pv_flag;
         o_pv_valid <= next_pv_valid;
         o_ext_irq_req <= next_ext_irq_req;
         o_int_irq_req <= next_int_irq_req;
         o_vector_high <= next_vector_high;
         o_global_irq_enable <= next_global_irq_enable;
         o_saved_irq_enable <= next_saved_irq_enable;
      end
   end

   vec_state_t vec_state;
   vec_state_t next_vec_state;
   logic [7:0] table_low;
   logic [7:0] next_table_low;
   logic [7:0] restart_low;
   logic [7:0] next_restart_low;
   logic [1:0] wait_cnt;
   logic [1:0] next_wait_cnt;
   logic second_read;
   logic [15:0] table_addr;
   logic trap_busy;

   // Table address former.
   // vector-high as upper byte
   vector_addr_gen u_addr (
      .i_vec_high(vector_high),
      .i_vec_low(next_table_low),
      .i_second(second_read),
      .o_addr(table_addr)
   );

   assign second_read = (next_vec_state == VEC_RD_HIGH);

   logic next_ext_vec_wait;
   logic next_mem_rd;
   logic next_restart_valid;
   logic [15:0] next_restart_addr;
   logic vec_done;
   logic [15:0] vec_restart;

   // Vectored fetch sequence: optional external byte, then two table reads.
   always_comb begin
      next_vec_state = vec_state;
      next_table_low = table_low;
      next_restart_low = restart_low;
      next_wait_cnt = wait_cnt;
      vec_done = 1'b0;
      vec_restart = {i_mem_rdata, restart_low};
      case (vec_state)
         VEC_IDLE: begin
            // no external wait states right after the trap state; the sequencer retries.
            if (i_vec.start && i_vec.external && !trap_busy) begin
               next_wait_cnt = 2'h0;
               next_vec_state = VEC_EXT_WAIT;
            end else if (i_vec.start && !i_vec.external) begin
               // low byte from vector-low and code
               next_table_low = {vector_low_reg, i_vec.src_code};
               next_vec_state = VEC_RD_LOW;
            end
         end
         VEC_EXT_WAIT: begin
            if (wait_cnt == EXT_WAIT_LAST) begin
               next_table_low = i_ext_vector;
               next_vec_state = VEC_RD_LOW;
            end else begin
               next_wait_cnt = 2'(wait_cnt + 2'h1);
            end
         end
         VEC_RD_LOW: begin
            if (i_mem_ack) begin
               next_restart_low = i_mem_rdata;
               next_vec_state = VEC_RD_HIGH;
            end
         end
         VEC_RD_HIGH: begin
            if (i_mem_ack) begin
               vec_done = 1'b1;
               next_vec_state = VEC_IDLE;
            end
         end
         default: begin
            next_vec_state = VEC_IDLE;
         end
      endcase
      next_ext_vec_wait = (next_vec_state == VEC_EXT_WAIT);
      next_mem_rd = (next_vec_state == VEC_RD_LOW) || (next_vec_state == VEC_RD_HIGH);
   end

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         vec_state <= VEC_IDLE;
         table_low <= 8'h00;
         restart_low <= 8'h00;
         wait_cnt <= 2'h0;
      end else begin
         vec_state <= next_vec_state;
         table_low <= next_table_low;
         restart_low <= next_restart_low;
         wait_cnt <= next_wait_cnt;
      end
   end

   trap_state_t trap_state;
   trap_state_t next_trap_state;
   logic [15:0] trap_pc;
   logic [15:0] next_trap_pc;
   logic next_trap_state_out;
   logic next_no_insert;
   logic next_trap_push;

   // A start now would put wait states in the cycle right after the insert state.
   assign trap_busy = i_undef.fetch || (trap_state == TRAP_INSERT);

   // Trap sequence: the insert state, then the restart at zero with nothing slipped in.
   // trap ignores global enable
   always_comb begin
      next_trap_state = trap_state;
      next_trap_pc = trap_pc;
      case (trap_state)
         TRAP_IDLE: begin
            if (i_undef.fetch) begin
               next_trap_pc = i_undef.pc;
               next_trap_state = TRAP_INSERT;
            end
         end
         TRAP_INSERT: begin
            next_trap_state = TRAP_AFTER;
         end
         TRAP_AFTER: begin
            next_trap_state = TRAP_IDLE;
         end
         default: begin
            next_trap_state = TRAP_IDLE;
         end
      endcase
      next_trap_state_out = (next_trap_state == TRAP_INSERT);
      next_no_insert = (next_trap_state == TRAP_AFTER);
      next_trap_push = (next_trap_state == TRAP_INSERT);
      // The trap owns the restart port when both finish together; a vector fetch is lost then.
      next_restart_valid = vec_done || (next_trap_state == TRAP_AFTER);
      next_restart_addr = vec_restart;
      if (next_trap_state == TRAP_AFTER) begin
         next_restart_addr = TRAP_RESTART;
      end
   end

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         trap_state <= TRAP_IDLE;
         trap_pc <= 16'h0000;
         o_trap_state <= 1'b0;
         o_no_insert <= 1'b0;
         o_trap_push <= 1'b0;
         o_trap_pc <= 16'h0000;
         o_ext_vec_wait <= 1'b0;
         o_mem_rd <= 1'b0;
         o_mem_addr <= 16'h0000;
         o_restart_valid <= 1'b0;
         o_restart_addr <= 16'h0000;
      end else begin
         trap_state <= next_trap_state;
         trap_pc <= next_trap_pc;
         o_trap_state <= next_trap_state_out;
         o_no_insert <= next_no_insert;
         o_trap_push <= next_trap_push;
         o_trap_pc <= next_trap_pc;
         o_ext_vec_wait <= next_ext_vec_wait;
         o_mem_rd <= next_mem_rd;
         o_mem_addr <= table_addr;
         o_restart_valid <= next_restart_valid;
         o_restart_addr <= next_restart_addr;
      end
   end

endmodule

// ===== sim/irq_ctl_asserts.sv
`timescale 1ns/1ps
// Port-level checks on the interrupt control block; all share the core clock.
module irq_ctl_asserts
   import irq_ctl_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_rst,
   input irq_ctl_pkg::io_req_t i_io,
   input irq_ctl_pkg::core_ops_t i_ops,
   input irq_ctl_pkg::vec_req_t i_vec,
   input irq_ctl_pkg::undef_t i_undef,
   input wire logic [7:0] o_io_rdata,
   input wire logic o_io_hit,
   input wire logic [7:0] o_vector_high,
   input wire logic o_pv_flag,
   input wire logic o_pv_valid,
   input wire logic o_global_irq_enable,
   input wire logic o_saved_irq_enable,
   input wire logic [2:0] o_ext_irq_req,
   input wire logic o_int_irq_req,
   input wire logic o_ext_vec_wait,
   input wire logic o_mem_rd,
   input wire logic [15:0] o_mem_addr,
   input wire logic o_restart_valid,
   input wire logic [15:0] o_restart_addr,
   input wire logic o_trap_state,
   input wire logic o_no_insert,
   input wire logic o_trap_push,
   input wire logic [15:0] o_trap_pc
);
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (i_rst);
   // A start is only taken while the fetch engine is free; single ops avoid priority cases.
   wire vidle = !o_mem_rd && !o_ext_vec_wait;
   wire solo = $onehot(i_ops);
   property p_nmi_entry;
      i_ops.nmi_accept |=> !o_global_irq_enable && o_saved_irq_enable == $past(o_global_irq_enable);
   endproperty
   a_nmi_entry: assert property (p_nmi_entry) else $error("nmi entry flags wrong");
   property p_nmi_return;
      solo && i_ops.nonmaskable_return_op |=>
         o_global_irq_enable == $past(o_saved_irq_enable) && $stable(o_saved_irq_enable);
   endproperty
   a_nmi_return: assert property (p_nmi_return) else $error("nmi return flags wrong");
   property p_enable;
      solo && i_ops.enable_irq_op |=> o_global_irq_enable && o_saved_irq_enable;
   endproperty
   a_enable: assert property (p_enable) else $error("enable op flags wrong");
   property p_accept;
      (i_ops.irq_accept || i_ops.disable_irq_op) && !i_ops.nmi_accept |=>
         !o_global_irq_enable && !o_saved_irq_enable;
   endproperty
   a_accept: assert property (p_accept) else $error("flags not cleared");
   property p_masked;
      !o_global_irq_enable |=> o_ext_irq_req == 3'h0 && !o_int_irq_req;
   endproperty
   a_masked: assert property (p_masked) else $error("request passed while disabled");
   property p_parity;
      solo && (i_ops.ld_a_from_i || i_ops.ld_a_from_r) |=>
         o_pv_valid && o_pv_flag == $past(o_global_irq_enable) && $stable(o_global_irq_enable);
   endproperty
   a_parity: assert property (p_parity) else $error("parity copy wrong");
   property p_read_low;
      i_io.rd && i_io.addr == VEC_LOW_ADDR |=> o_io_hit && o_io_rdata[4:0] == 5'h00;
   endproperty
   a_read_low: assert property (p_read_low) else $error("vector low read wrong");
   property p_read_ctl;
      i_io.rd && i_io.addr == TRAP_CTL_ADDR |=> o_io_hit && o_io_rdata[5:3] == 3'h0;
   endproperty
   a_read_ctl: assert property (p_read_ctl) else $error("control read wrong");
   property p_table_addr;
      i_vec.start && !i_vec.external && vidle |=> o_mem_rd && o_mem_addr[15:8] == $past(o_vector_high)
         && o_mem_addr[4:0] == $past(i_vec.src_code);
   endproperty
   a_table_addr: assert property (p_table_addr) else $error("table address wrong");
   property p_ext_wait;
      i_vec.start && i_vec.external && vidle && !i_undef.fetch && !o_trap_state |=>
         o_ext_vec_wait [*2] ##1 !o_ext_vec_wait;
   endproperty
   a_ext_wait: assert property (p_ext_wait) else $error("wait states wrong");
   property p_trap_seq;
      i_undef.fetch && !o_trap_state && !o_no_insert |=> o_trap_state && o_trap_push &&
         o_trap_pc == $past(i_undef.pc) ##1 o_no_insert && o_restart_valid && o_restart_addr == TRAP_RESTART;
   endproperty
   a_trap_seq: assert property (p_trap_seq) else $error("trap sequence wrong");
   property p_no_insert;
      o_trap_state |=> o_no_insert && !o_ext_vec_wait;
   endproperty
   a_no_insert: assert property (p_no_insert) else $error("cycle inserted after trap");
   property p_trap_flags;
      i_undef.fetch && i_ops == '0 |=> $stable(o_global_irq_enable) && $stable(o_saved_irq_enable);
   endproperty
   a_trap_flags: assert property (p_trap_flags) else $error("trap changed flags");
endmodule

// ===== sim/vec_table_model.sv
`timescale 1ns/1ps
// Vector table memory; the slow mode makes the low read wait three more cycles and the high read two more.
module vec_table_model (
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_slow,
   input wire logic i_mem_rd,
   input wire logic [15:0] i_mem_addr,
   output logic o_mem_ack,
   output logic [7:0] o_mem_rdata
);
   logic [1:0] wait_cnt;
   // byte per address
   // Between answers the data lines flip, so a late sample cannot match by chance.
   always @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         o_mem_ack <= 1'b0;
         o_mem_rdata <= 8'h00;
         wait_cnt <= 2'h0;
      end else if (i_mem_rd && !o_mem_ack && (wait_cnt == 2'h3 || !i_slow)) begin
         o_mem_ack <= 1'b1;
         o_mem_rdata <= i_mem_addr[7:0] ^ i_mem_addr[15:8] ^ 8'h3c;
         wait_cnt <= 2'h0;
      end else begin
         o_mem_ack <= 1'b0;
         o_mem_rdata <= ~o_mem_rdata;
         wait_cnt <= i_mem_rd ? wait_cnt + 2'h1 : 2'h0;
      end
   end
endmodule

// ===== sim/tb_top.sv
`timescale 1ns/1ps
// Self-checking bench for the interrupt and trap control block.
module tb_top;
   import irq_ctl_pkg::*;
   logic i_core_clk = 1'b0;
   logic i_rst = 1'b1;
   io_req_t i_io = '0;
   core_ops_t i_ops = '0;
   vec_req_t i_vec = '0;
   undef_t i_undef = '0;
   logic [7:0] i_acc = 8'h00;
   logic [2:0] i_ext_irq = 3'h0;
   logic [7:0] i_int_irq = 8'h00;
   logic [7:0] i_ext_vector = 8'h00;
   logic slow = 1'b0;
   logic i_mem_ack, o_io_hit, o_pv_flag, o_pv_valid, o_global_irq_enable, o_saved_irq_enable;
   logic o_int_irq_req, o_ext_vec_wait, o_mem_rd, o_restart_valid, o_trap_state, o_no_insert, o_trap_push;
   logic [7:0] i_mem_rdata, o_io_rdata, o_vector_high;
   logic [15:0] o_mem_addr, o_restart_addr, o_trap_pc;
   logic [2:0] o_ext_irq_req;
   int failures = 0;
   int compares = 0;
   int cycles = 0;
   logic [15:0] q_rd[$];
   logic [15:0] q_rs[$];
   logic g = 1'b0;
   logic s = 1'b0;
   logic third = 1'b0;
   logic [2:0] en = EXT_EN_RST;
   logic [7:0] il = 8'h00;
   logic [7:0] vh = 8'h00;

   vectored_irq_and_trap_control #(.NUM_INT_SRC(8)) u_dut (
      .i_core_clk, .i_rst, .i_io, .i_ops, .i_acc, .i_ext_irq, .i_int_irq, .i_vec, .i_ext_vector,
      .i_mem_ack, .i_mem_rdata, .i_undef, .o_io_rdata, .o_io_hit, .o_vector_high, .o_pv_flag,
      .o_pv_valid, .o_global_irq_enable, .o_saved_irq_enable, .o_ext_irq_req, .o_int_irq_req,
      .o_ext_vec_wait, .o_mem_rd, .o_mem_addr, .o_restart_valid, .o_restart_addr, .o_trap_state,
      .o_no_insert, .o_trap_push, .o_trap_pc);
   vec_table_model u_mem (.i_core_clk, .i_rst, .i_slow(slow), .i_mem_rd(o_mem_rd),
      .i_mem_addr(o_mem_addr), .o_mem_ack(i_mem_ack), .o_mem_rdata(i_mem_rdata));

   // Free-running core clock.
   initial begin
      forever #(CLK_PERIOD_NS / 2) i_core_clk = ~i_core_clk;
   end

   function automatic logic [7:0] tbl(input logic [15:0] a);
      return a[7:0] ^ a[15:8] ^ 8'h3c;
   endfunction

   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic tick;
      @(posedge i_core_clk);
      #10;
   endtask

   task automatic give_verdict;
      $display("Counts: %0d compares, %0d failures", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // One register access; for a mapped read, d carries the expected value.
   task automatic io_acc(input logic wr, input logic [7:0] a, input logic [7:0] d);
      i_io = '{wr: wr, rd: !wr, addr: a, wdata: d};
      if (!wr && (a == VEC_LOW_ADDR || a == TRAP_CTL_ADDR)) q_rd.push_back({8'h00, d});
      tick;
      i_io = '0;
      tick;
   endtask

   task automatic pulse(input core_ops_t o);
      i_ops = o;
      tick;
      i_ops = '0;
      tick;
   endtask

   // Table fetch; the restart address is built low byte first from the model's table.
   task automatic vfetch(input logic ext, input logic [4:0] code);
      logic [15:0] t;
      int n;
      t = ext ? {vh, i_ext_vector} : {vh, il[7:5], code};
      q_rs.push_back({tbl(t + 16'h1), tbl(t)});
      i_vec = '{start: 1'b1, external: ext, src_code: code};
      tick;
      i_vec = '0;
      n = 0;
      while (!o_restart_valid && n < 30) begin
         tick;
         n++;
      end
      if (n == 30) failures++;
      tick;
   endtask

   // Each answer is matched against the oldest pending note; an unasked answer fails.
   always @(negedge i_core_clk) begin
      if (!i_rst && o_io_hit) begin
         if (q_rd.size() == 0) check("read hit", 16'h0000, 16'h0001);
         else check("register read", q_rd.pop_front(), {8'h00, o_io_rdata});
      end
      if (!i_rst && o_restart_valid) begin
         if (q_rs.size() == 0) check("restart", 16'h0000, 16'h0001);
         else check("restart address", q_rs.pop_front(), o_restart_addr);
      end
   end

   // Hang guard; the whole run needs well under a thousand cycles.
   always @(posedge i_core_clk) begin
      cycles++;
      if (cycles == 3000) begin
         failures++;
         give_verdict;
      end
   end

   initial begin
      logic [7:0] r;
      int k;
      void'($urandom(3404));
      repeat (4) @(posedge i_core_clk);
      #10;
      i_rst = 1'b0;
      check("vector high", 16'h0000, {8'h00, o_vector_high});
      io_acc(1'b0, VEC_LOW_ADDR, 8'h00);
      io_acc(1'b0, TRAP_CTL_ADDR, 8'h01);
      io_acc(1'b0, 8'h35, 8'h00);
      $display("Test reset values done");
      r = 8'($urandom);
      il = r;
      io_acc(1'b1, VEC_LOW_ADDR, r);
      io_acc(1'b0, VEC_LOW_ADDR, {r[7:5], 5'h00});
      io_acc(1'b1, TRAP_CTL_ADDR, 8'hff);
      en = 3'h7;
      io_acc(1'b0, TRAP_CTL_ADDR, 8'h07);
      $display("Test register access done");
      // Random op stream against a small reference of both enable flags.
      repeat (48) begin
         k = $urandom_range(8, 0);
         i_acc = 8'($urandom);
         i_ext_irq = 3'($urandom);
         i_int_irq = 8'($urandom);
         pulse(core_ops_t'(9'h1 << k));
         if (k == 0) vh = i_acc;
         if (k == 8) {g, s} = 2'b11;
         if (k == 7 || k == 3) {g, s} = 2'b00;
         if (k == 4) {g, s} = {1'b0, g};
         if (k == 6) g = s;
         check("vector high", {8'h00, vh}, {8'h00, o_vector_high});
         check("global enable", {15'h0, g}, {15'h0, o_global_irq_enable});
         check("saved enable", {15'h0, s}, {15'h0, o_saved_irq_enable});
         if (k == 1 || k == 2) check("parity copy", {15'h0, g}, {15'h0, o_pv_flag});
         check("ext requests", {13'h0, i_ext_irq & en & {3{g}}}, {13'h0, o_ext_irq_req});
         check("int request", {15'h0, g & (|i_int_irq)}, {15'h0, o_int_irq_req});
      end
      $display("Test enable flags done");
      i_ext_vector = 8'($urandom);
      for (k = 0; k < 6; k++) begin
         slow = k[0];
         vfetch(k == 5, 5'($urandom));
      end
      $display("Test vector fetch done");
      third = 1'($urandom);
      i_undef = '{fetch: 1'b1, third_byte: third, pc: 16'($urandom)};
      q_rs.push_back(TRAP_RESTART);
      tick;
      i_undef.fetch = 1'b0;
      check("pushed counter", i_undef.pc, o_trap_pc);
      tick;
      io_acc(1'b0, TRAP_CTL_ADDR, {1'b1, third, 3'h0, en});
      io_acc(1'b1, TRAP_CTL_ADDR, 8'h38);
      en = 3'h0;
      io_acc(1'b0, TRAP_CTL_ADDR, {1'b0, third, 6'h00});
      $display("Test trap done");
      give_verdict;
   end
endmodule

bind vectored_irq_and_trap_control irq_ctl_asserts u_chk (.i_core_clk, .i_rst, .i_io, .i_ops, .i_vec,
   .i_undef, .o_io_rdata, .o_io_hit, .o_vector_high, .o_pv_flag, .o_pv_valid, .o_global_irq_enable,
   .o_saved_irq_enable, .o_ext_irq_req, .o_int_irq_req, .o_ext_vec_wait, .o_mem_rd, .o_mem_addr,
   .o_restart_valid, .o_restart_addr, .o_trap_state, .o_no_insert, .o_trap_push, .o_trap_pc);
